// >>> inc/scs_pkg.sv
// Shared constants and carrier types for the system clock source selector.
// Assumes a single 20 MHz system clock and an AXI4-Lite register master.
`default_nettype none

package scs_pkg;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int unsigned CLK_NS     = 50;
  // Oscillator warm-up delay; the figure is a plain default.
  localparam int unsigned WARMUP_NS  = 2000;
  localparam int unsigned WARMUP_CYC = (WARMUP_NS + CLK_NS - 1) / CLK_NS;
  // Longest gap between external clock edges before a failure is declared.
  localparam int unsigned FAIL_NS    = 20000;
  localparam int unsigned FAIL_CYC   = FAIL_NS / CLK_NS;
  localparam logic [10:0] OST_LAST   = 11'h3ff;
  localparam logic [5:0]  WARM_LAST  = 6'(WARMUP_CYC - 1);
  localparam logic [9:0]  FAIL_LAST  = 10'(FAIL_CYC - 1);

  // ********************************************************************
  // Register map and fields
  // ********************************************************************
  localparam logic [11:0] ADDR_OSC_CTRL = 12'h000;
  localparam logic [11:0] ADDR_CLK_STAT = 12'h004;
  localparam int unsigned INTERNAL_FREQ_SELECT_LSB      = 4;
  localparam int unsigned STARTUP_DONE_STATUS_BIT      = 3;
  localparam int unsigned HTS_BIT       = 2;
  localparam int unsigned LTS_BIT       = 1;
  localparam int unsigned SCS_BIT       = 0;
  localparam logic [2:0]  INTERNAL_FREQ_SELECT_RESET    = 3'h6;
  localparam logic [2:0]  INTERNAL_FREQ_SELECT_FAST     = 3'h7;
  localparam logic [2:0]  INTERNAL_FREQ_SELECT_SLOW     = 3'h0;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_DECERR   = 2'h3;

  // Source index 8 is the external pin; 0 to 7 follow the frequency field.
  localparam logic [3:0]  SRC_EXT       = 4'h8;

  typedef enum logic [2:0] {
    MODE_EXT_CLK   = 3'h0,
    MODE_XTAL_LOW  = 3'h1,
    MODE_XTAL_MED  = 3'h2,
    MODE_XTAL_HIGH = 3'h3,
    MODE_RC        = 3'h4,
    MODE_RC_IO     = 3'h5,
    MODE_INT_OUT   = 3'h6,
    MODE_INT_IO    = 3'h7
  } scs_mode_t;

  typedef struct packed {
    scs_mode_t mode;
    logic      two_speed;
    logic      failsafe_en;
    logic      powerup_timer_en;
  } scs_cfg_t;

  typedef struct packed {
    logic        awvalid;
    logic [11:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [11:0] araddr;
    logic        rready;
  } scs_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } scs_axi_rsp_t;

endpackage

`default_nettype wire

// >>> src/scs_clkswitch.sv
// Glitch-free source switch for sampled clock levels.
// Assumes every source level is already synchronised to sys_clk_in.
`default_nettype none

module scs_clkswitch
  import scs_pkg::*;
(
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  input  wire logic [8:0] src_in,
  input  wire logic [3:0] sel_in,
  input  wire logic       force_in,
  output var  logic       clk_out,
  output var  logic [3:0] cur_out,
  output var  logic       busy_out
);

  typedef enum logic [2:0] {
    SW_RUN  = 3'b001,
    SW_FALL = 3'b010,
    SW_LOW  = 3'b100
  } scs_sw_st_t;

  scs_sw_st_t st_q;
  logic [8:0] prev_q;
  logic [3:0] tgt_q;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      prev_q <= '0;
    end else begin
      prev_q <= src_in;
    end
  end

  // ********************************************************************
  // Switch sequence
  // ********************************************************************
  // A dead source never falls, so a forced change skips that wait.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st_q    <= SW_RUN;
      cur_out <= {1'b0, INTERNAL_FREQ_SELECT_RESET};
      tgt_q   <= {1'b0, INTERNAL_FREQ_SELECT_RESET};
      clk_out <= 1'b0;
    end else begin
      case (st_q)
        SW_RUN: begin
          clk_out <= src_in[cur_out];
          if (sel_in != cur_out) begin
            st_q <= SW_FALL;
          end
        end
        SW_FALL: begin
          if ((prev_q[cur_out] && !src_in[cur_out]) || force_in) begin // see RL17
            st_q    <= SW_LOW;
            tgt_q   <= sel_in;
            clk_out <= 1'b0;
          end else begin
            clk_out <= src_in[cur_out];
          end
        end
        SW_LOW: begin
          clk_out <= 1'b0; // see RL18
          if (!prev_q[tgt_q] && src_in[tgt_q]) begin // see RL17
            cur_out <= tgt_q;
            clk_out <= 1'b1;
            st_q    <= SW_RUN;
          end
        end
        default: begin
          st_q <= SW_RUN;
        end
      endcase
    end
  end

  assign busy_out = (st_q != SW_RUN);

  a_connect_on_rise: assert property ( // see RL17
    $changed(cur_out) |-> clk_out && $past(st_q == SW_LOW) && $past(src_in[tgt_q]) &&
    !$past(prev_q[tgt_q]))
    else $error("new source connected away from its rising edge");

  a_hold_low_gap: assert property ( // see RL18
    (st_q == SW_FALL) ##1 (st_q == SW_LOW) |-> !clk_out ##1 (!clk_out || $changed(cur_out)))
    else $error("clock not held low between sources");

endmodule

`default_nettype wire

// >>> src/scs_top.sv
// System clock source selector: mode decode, start-up sequencing,
// fail-safe fallback, pin reuse and the oscillator control register.
// Assumes oscillator levels arrive asynchronously from pins or analog cells.
//
// Our own choices: the AXI4-Lite register port and the register addresses.
`default_nettype none

// Functional notes
// RL1 - Eight clock modes from three-bit field
// RL2 - Frequency field picks eight internal rates
// RL3 - Frequency field resets to 4 MHz
// RL4 - Bit 3 shows configured clock running
// RL5 - Bit 3 resets low for fail-safe/two-speed
// RL6 - Bit 2 shows fast internal stable
// RL7 - Bit 1 shows slow internal stable
// RL8 - Bit 0 selects internal over configured
// RL9 - Crystal modes count 1024 oscillator edges
// RL10 - CPU stalled while start-up count runs
// RL11 - Internal modes wait warm-up delay
// RL12 - External clock mode starts without count
// RL13 - Static logic halts and resumes losslessly
// RL14 - External clock on pin A, B free
// RL15 - Divide-by-four out on B; IO modes free
// RL16 - Fail-safe falls back to internal oscillator
// RL17 - Switch waits fall, holds low, rise
// RL18 - No shortened pulse on system clock
module scs_top
  import scs_pkg::*;
(
  input  wire logic         sys_clk_in,
  input  wire logic         rst_in,
  input  wire scs_axi_req_t axi_req_in,
  output var  scs_axi_rsp_t axi_rsp_out,
  input  wire scs_cfg_t     nonvolatile_config_word_in,
  input  wire logic         oscillator_pin_a_in,
  input  wire logic         fast_internal_oscillator_in,
  input  wire logic         slow_internal_oscillator_in,
  input  wire logic         fast_ready_in,
  input  wire logic         slow_ready_in,
  input  wire logic         powerup_timer_done_in,
  input  wire logic         sleep_in,
  output var  logic         sys_clock_out,
  output var  logic         cpu_stall_out,
  output var  logic         failsafe_active_out,
  output var  logic         pin_a_gpio_free_out,
  output var  logic         pin_b_gpio_free_out,
  output var  logic         divided_clock_output_out,
  output var  logic         divided_clock_oe_n_out
);

  // ********************************************************************
  // Mode decode
  // ********************************************************************
  function automatic logic is_crystal(input scs_mode_t m);
    return (m == MODE_XTAL_LOW) || (m == MODE_XTAL_MED) || (m == MODE_XTAL_HIGH);
  endfunction

  function automatic logic is_internal(input scs_mode_t m);
    return (m == MODE_INT_OUT) || (m == MODE_INT_IO);
  endfunction

  function automatic logic is_rc(input scs_mode_t m);
    return (m == MODE_RC) || (m == MODE_RC_IO);
  endfunction

  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] r);
    return a[11:2] == r[11:2];
  endfunction

  typedef enum logic [5:0] {
    PH_INIT  = 6'b000001,
    PH_POWERUP_TIMER  = 6'b000010,
    PH_OST   = 6'b000100,
    PH_WARM  = 6'b001000,
    PH_RUN   = 6'b010000,
    PH_SLEEP = 6'b100000
  } scs_phase_t;

  scs_cfg_t   cfg_q;
  scs_phase_t ph_q;
  scs_phase_t ph_d;
  logic [10:0] ost_cnt_q;
  logic [5:0]  warm_cnt_q;
  logic [9:0]  fs_cnt_q;
  logic [2:0]  internal_freq_select_q;
  logic        system_clock_select_q;
  logic        startup_done_status_q;
  logic        fallback_q;
  logic [2:0]  sync_a_q;
  logic [2:0]  sync_f_q;
  logic [1:0]  sync_s_q;
  logic [1:0]  sync_fr_q;
  logic [1:0]  sync_sr_q;
  logic [5:0]  post_q;
  logic [8:0]  src;
  logic [3:0]  sel;
  logic [3:0]  cur;
  logic        sw_busy;
  logic        sw_clk;
  logic        ext_rise;
  logic        xtal_2spd;
  logic        using_cfg;
  logic        fs_armed;
  logic        sys_prev_q;
  logic [1:0]  quarter_q;

  assign ext_rise  = sync_a_q[1] && !sync_a_q[2];
  assign xtal_2spd = cfg_q.two_speed && is_crystal(cfg_q.mode);

  // ********************************************************************
  // Synchronisers and postscaler
  // ********************************************************************
  // No reset here: the chains keep tracking the pins through reset, so the
  // edge detectors cannot report a false rise when reset ends.
  always_ff @(posedge sys_clk_in) begin
    sync_a_q  <= {sync_a_q[1:0], oscillator_pin_a_in};
    sync_f_q  <= {sync_f_q[1:0], fast_internal_oscillator_in};
    sync_s_q  <= {sync_s_q[0], slow_internal_oscillator_in};
    sync_fr_q <= {sync_fr_q[0], fast_ready_in};
    sync_sr_q <= {sync_sr_q[0], slow_ready_in};
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      post_q <= '0;
    end else if (sync_f_q[1] && !sync_f_q[2]) begin
      post_q <= post_q + 6'h01;
    end
  end

  // Tap k of the postscaler gives the fast oscillator over 2 to the 7-k.
  always_comb begin
    src = '0;
    src[INTERNAL_FREQ_SELECT_SLOW] = sync_s_q[1]; // see RL2
    src[INTERNAL_FREQ_SELECT_FAST] = sync_f_q[1];
    for (int k = 1; k < 7; k++) begin
      src[k] = post_q[6 - k]; // see RL2
    end
    src[SRC_EXT] = sync_a_q[1]; // see RL14
  end

  // ********************************************************************
  // Start-up sequencing
  // ********************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cfg_q <= '0;
    end else if (ph_q == PH_INIT) begin
      cfg_q <= nonvolatile_config_word_in; // see RL1
    end
  end

  always_comb begin
    ph_d = ph_q;
    case (ph_q)
      PH_INIT: begin
        ph_d = PH_POWERUP_TIMER;
      end
      PH_POWERUP_TIMER, PH_SLEEP: begin
        if ((ph_q == PH_POWERUP_TIMER && (!cfg_q.powerup_timer_en || powerup_timer_done_in)) ||
            (ph_q == PH_SLEEP && !sleep_in)) begin
          if (is_crystal(cfg_q.mode)) begin
            ph_d = PH_OST; // see RL9
          end else if (is_internal(cfg_q.mode)) begin
            ph_d = PH_WARM; // see RL11
          end else begin
            ph_d = PH_RUN; // see RL12
          end
        end
      end
      PH_OST: begin
        if (ext_rise && ost_cnt_q == OST_LAST) begin
          ph_d = PH_RUN; // see RL9
        end
      end
      PH_WARM: begin
        if (warm_cnt_q == WARM_LAST) begin
          ph_d = PH_RUN; // see RL11
        end
      end
      PH_RUN: begin
        if (sleep_in) begin
          ph_d = PH_SLEEP;
        end
      end
      default: begin
        ph_d = PH_INIT;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ph_q <= PH_INIT;
    end else begin
      ph_q <= ph_d;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in || ph_q != PH_OST) begin
      ost_cnt_q <= '0;
    end else if (ext_rise) begin
      ost_cnt_q <= ost_cnt_q + 11'h001; // see RL9
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in || ph_q != PH_WARM) begin
      warm_cnt_q <= '0;
    end else begin
      warm_cnt_q <= warm_cnt_q + 6'h01;
    end
  end

  // Two-speed start lets code run on the internal clock during the count.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cpu_stall_out <= 1'b1;
    end else begin
      cpu_stall_out <= (ph_d != PH_RUN) && !(ph_d == PH_OST && xtal_2spd); // see RL10
    end
  end

  // ********************************************************************
  // Fail-safe monitor
  // ********************************************************************
  assign fs_armed = (ph_q == PH_RUN) && cfg_q.failsafe_en && !fallback_q &&
                    !is_internal(cfg_q.mode);

  always_ff @(posedge sys_clk_in) begin
    if (rst_in || !fs_armed || ext_rise) begin
      fs_cnt_q <= '0;
    end else begin
      fs_cnt_q <= fs_cnt_q + 10'h001;
    end
  end

  // Fallback lasts until reset or sleep, which restarts the source.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || ph_q == PH_SLEEP) begin
      fallback_q <= 1'b0;
    end else if (fs_armed && !ext_rise && fs_cnt_q == FAIL_LAST) begin
      fallback_q <= 1'b1; // see RL16
    end
  end

  assign failsafe_active_out = fallback_q;

  // ********************************************************************
  // Source selection
  // ********************************************************************
  always_comb begin
    if (system_clock_select_q || fallback_q || is_internal(cfg_q.mode) ||
        (xtal_2spd && ph_q != PH_RUN)) begin
      sel = {1'b0, internal_freq_select_q}; // see RL8
    end else begin
      sel = SRC_EXT; // see RL8
    end
  end

  // Stopping sys_clk_in simply freezes every state; see RL13.
  scs_clkswitch u_switch (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .src_in     (src),
    .sel_in     (sel),
    .force_in   (fallback_q),
    .clk_out    (sw_clk),
    .cur_out    (cur),
    .busy_out   (sw_busy)
  );

  assign sys_clock_out = sw_clk;
  assign using_cfg = is_internal(cfg_q.mode) || (cur == SRC_EXT && !sw_busy);

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      startup_done_status_q <= 1'b1;
    end else if (ph_q == PH_INIT) begin
      startup_done_status_q <= !(nonvolatile_config_word_in.failsafe_en || // see RL5
        (nonvolatile_config_word_in.two_speed &&
         is_crystal(nonvolatile_config_word_in.mode)));
    end else if (ph_q == PH_RUN) begin
      startup_done_status_q <= using_cfg; // see RL4
    end
  end

  // ********************************************************************
  // Pin reuse
  // ********************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      sys_prev_q <= 1'b0;
      quarter_q  <= '0;
    end else begin
      sys_prev_q <= sw_clk;
      if (sw_clk && !sys_prev_q) begin
        quarter_q <= quarter_q + 2'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      divided_clock_output_out <= 1'b0;
      divided_clock_oe_n_out   <= 1'b1;
      pin_a_gpio_free_out      <= 1'b0;
      pin_b_gpio_free_out      <= 1'b0;
    end else begin
      divided_clock_output_out <= quarter_q[1]; // see RL15
      divided_clock_oe_n_out   <= !(cfg_q.mode == MODE_RC || cfg_q.mode == MODE_INT_OUT);
      pin_a_gpio_free_out      <= is_internal(cfg_q.mode); // see RL14
      pin_b_gpio_free_out      <= cfg_q.mode == MODE_EXT_CLK || cfg_q.mode == MODE_RC_IO ||
                                  cfg_q.mode == MODE_INT_IO; // see RL15
    end
  end

  // ********************************************************************
  // AXI4-Lite slave
  // ********************************************************************
  logic        awready_q;
  logic        wready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic        aw_have_q;
  logic        w_have_q;
  logic [11:0] awaddr_q;
  logic [7:0]  wbyte_q;
  logic        wlane_q;
  logic        do_write;
  logic [7:0]  ctrl_rd;

  assign axi_rsp_out = '{awready_q, wready_q, bvalid_q, bresp_q,
                         arready_q, rvalid_q, rdata_q, rresp_q};
  assign do_write = aw_have_q && w_have_q && !bvalid_q;
  assign ctrl_rd = {1'b0, internal_freq_select_q, startup_done_status_q, // see RL4
                    sync_fr_q[1], sync_sr_q[1], system_clock_select_q}; // see RL6 RL7

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= '0;
      wbyte_q   <= '0;
      wlane_q   <= 1'b0;
    end else begin
      awready_q <= axi_req_in.awvalid && !awready_q && !aw_have_q && !bvalid_q;
      wready_q  <= axi_req_in.wvalid && !wready_q && !w_have_q && !bvalid_q;
      if (axi_req_in.awvalid && awready_q) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= axi_req_in.awaddr;
      end else if (do_write) begin
        aw_have_q <= 1'b0;
      end
      if (axi_req_in.wvalid && wready_q) begin
        w_have_q <= 1'b1;
        wbyte_q  <= axi_req_in.wdata[7:0];
        wlane_q  <= axi_req_in.wstrb[0];
      end else if (do_write) begin
        w_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (addr_hit(awaddr_q, ADDR_OSC_CTRL) || addr_hit(awaddr_q, ADDR_CLK_STAT)) ?
                  RESP_OKAY : RESP_DECERR;
    end else if (axi_req_in.bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      internal_freq_select_q <= INTERNAL_FREQ_SELECT_RESET; // see RL3
      system_clock_select_q  <= 1'b0;
    end else if (do_write && wlane_q && addr_hit(awaddr_q, ADDR_OSC_CTRL)) begin
      internal_freq_select_q <= wbyte_q[INTERNAL_FREQ_SELECT_LSB +: 3]; // see RL2
      system_clock_select_q  <= wbyte_q[SCS_BIT]; // see RL8
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
    end else begin
      arready_q <= axi_req_in.arvalid && !arready_q && !rvalid_q;
      if (axi_req_in.arvalid && arready_q) begin
        rvalid_q <= 1'b1;
        rresp_q  <= RESP_OKAY;
        rdata_q  <= '0;
        if (addr_hit(axi_req_in.araddr, ADDR_OSC_CTRL)) begin
          rdata_q <= {24'h000000, ctrl_rd};
        end else if (addr_hit(axi_req_in.araddr, ADDR_CLK_STAT)) begin
          rdata_q <= {29'h00000000, cpu_stall_out, sw_busy, fallback_q};
        end else begin
          rresp_q <= RESP_DECERR;
        end
      end else if (axi_req_in.rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ********************************************************************
  // Assertions
  // ********************************************************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  a_freq_reset_val: assert property ($past(rst_in) |-> internal_freq_select_q == INTERNAL_FREQ_SELECT_RESET) // see RL3
    else $error("frequency field not 110 after reset");

  a_ost_full_count: assert property ( // see RL9
    (ph_q == PH_OST && ost_cnt_q != OST_LAST) |=> ph_q != PH_RUN)
    else $error("crystal start-up ended before 1024 edges");

  a_ost_stall_cpu: assert property ( // see RL10
    (ph_q == PH_OST && !xtal_2spd) |-> cpu_stall_out)
    else $error("cpu ran during the start-up count");

  a_warm_stall_cpu: assert property ( // see RL11
    (ph_q == PH_WARM) |-> cpu_stall_out ##1 (ph_q != PH_RUN || $past(warm_cnt_q) == WARM_LAST))
    else $error("internal clock used before warm-up");

  a_ec_no_delay: assert property ( // see RL12
    (ph_q == PH_POWERUP_TIMER && cfg_q.mode == MODE_EXT_CLK && !cfg_q.powerup_timer_en) |=> ph_q == PH_RUN ##1
    !cpu_stall_out)
    else $error("external clock mode waited on start-up");

  a_fail_fallback: assert property ( // see RL16
    (fs_armed && !ext_rise && fs_cnt_q == FAIL_LAST) |=> fallback_q ##[1:40] !sw_busy &&
    cur[3] == 1'b0)
    else $error("no fallback to internal oscillator");

  a_startup_done_status_reset_low: assert property ( // see RL5
    ($past(ph_q == PH_INIT) && cfg_q.failsafe_en) |-> !startup_done_status_q)
    else $error("start-up status not cleared with fail-safe");

  a_divout_modes: assert property ( // see RL15
    !divided_clock_oe_n_out |-> cfg_q.mode == MODE_RC || cfg_q.mode == MODE_INT_OUT)
    else $error("divided clock driven in wrong mode");

  a_ext_pin_b_free: assert property ( // see RL14
    (!$past(rst_in) && $past(cfg_q.mode == MODE_EXT_CLK)) |->
    pin_b_gpio_free_out && !pin_a_gpio_free_out)
    else $error("pin release wrong in external clock mode");

endmodule

`default_nettype wire

// >>> verif/scs_osc_model.sv
// Behavioural external oscillator that drives pin A of the selector.
// Assumes the bench starts and stops it through run_in.
`default_nettype none
module scs_osc_model (
  input  wire logic run_in,
  output var  logic pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Oscillation
  // ****
  // A stopped source holds its level, just as a dead crystal would.
  initial pin_out = 1'b0;
  always begin
    #115;
    if (run_in) pin_out = ~pin_out;
  end
endmodule
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the clock source selector.
// Assumes scs_osc_model drives pin A and the bench drives the internal oscillators.
`default_nettype none
module tb
  import scs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  scs_axi_req_t req;
  scs_axi_rsp_t rsp;
  scs_cfg_t     cfg = '0;
  logic         fo = 1'b0, so = 1'b0, frdy = 1'b1, srdy = 1'b1, run = 1'b1, pin;
  logic         stall, fsafe, afree, bfree, oen, sclk, dclk, slp = 1'b0;
  int           cyc = 0, edges = 0, fail_count = 0, compares = 0, sedges = 0, dedges = 0;
  always #25 clk = ~clk;
  always @(posedge pin) edges++;
  always @(posedge sclk) sedges++;
  always @(posedge dclk) dedges++;
  scs_osc_model osc (.run_in(run), .pin_out(pin));
  scs_top dut (.sys_clk_in(clk), .rst_in(rst), .axi_req_in(req), .axi_rsp_out(rsp),
    .nonvolatile_config_word_in(cfg), .oscillator_pin_a_in(pin),
    .fast_internal_oscillator_in(fo), .slow_internal_oscillator_in(so),
    .fast_ready_in(frdy), .slow_ready_in(srdy), .powerup_timer_done_in(1'b1),
    .sleep_in(slp), .sys_clock_out(sclk), .cpu_stall_out(stall), .failsafe_active_out(fsafe),
    .pin_a_gpio_free_out(afree), .pin_b_gpio_free_out(bfree),
    .divided_clock_output_out(dclk), .divided_clock_oe_n_out(oen));
  always @(posedge clk) begin
    cyc <= cyc + 1;
    fo <= ~fo;
    if (cyc[2:0] == 0) so <= ~so;
    if (cyc == 40000) begin
      fail_count++;
      final_report();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'h1;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    r = rsp.bresp;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    r = rsp.rresp;
  endtask
  task automatic rst_cfg(input scs_cfg_t c);
    rst <= 1'b1;
    cfg <= c;
    repeat (4) @(posedge clk);
    edges = 0;
    rst <= 1'b0;
    @(posedge clk);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_xtal();
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    rst_cfg('{MODE_XTAL_LOW, 1'b0, 1'b0, 1'b0});
    chk("stall", stall, 1);
    rd(ADDR_OSC_CTRL, d, r);
    chk("freq_rst", d[7:4], {1'b0, INTERNAL_FREQ_SELECT_RESET});
    for (n = 0; n < 8000 && stall === 1'b1; n++) @(posedge clk);
    chk("ost_edges", edges >= 1024 && edges <= 1030, 1);
    repeat (20) @(posedge clk);
    rd(ADDR_OSC_CTRL, d, r);
    chk("status", d[3:1], 3'h7);
    frdy <= 1'b0;
    srdy <= 1'b0;
    repeat (8) @(posedge clk);
    rd(ADDR_OSC_CTRL, d, r);
    chk("fast_stable", d[2], 0);
    chk("slow_stable", d[1], 0);
    frdy <= 1'b1;
    srdy <= 1'b1;
  endtask
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    for (n = 0; n < 8; n++) begin
      wr(ADDR_OSC_CTRL, {n[2:0], 4'h1}, r);
      rd(ADDR_OSC_CTRL, d, r);
      chk("freq_sel", {d[7:4], d[0]}, {2'b00, n[2:0], 1'b1});
    end
    wr(ADDR_OSC_CTRL, 32'h60, r);
    rd(ADDR_OSC_CTRL, d, r);
    chk("sel_clear", d[0], 0);
    wr(12'h010, 32'h1, r);
    chk("bresp", r, RESP_DECERR);
    rd(12'h010, d, r);
    chk("rresp", r, RESP_DECERR);
    chk("rdata", d, 0);
  endtask
  task automatic t_modes();
    int         n;
    int         k;
    logic       ok;
    logic [2:0] pins_exp;
    for (n = 0; n < 8; n++) begin
      rst_cfg('{scs_mode_t'(n), 1'b0, 1'b0, 1'b0});
      if (n >= 6) begin
        for (k = 0; k < 200 && stall === 1'b1; k++) @(posedge clk);
        chk("warmup", k, WARMUP_CYC + 2);
      end
      if (n == 6) begin
        sedges = 0;
        dedges = 0;
        repeat (160) @(posedge clk);
        ok = sedges > 20 && 4 * dedges >= sedges - 4 && 4 * dedges <= sedges + 4;
        chk("divout", ok, 1);
      end
      repeat (10) @(posedge clk);
      pins_exp = {n >= 6, n == 0 || n == 5 || n == 7, !(n == 4 || n == 6)};
      chk("pins", {afree, bfree, oen}, pins_exp);
    end
  endtask
  task automatic t_fail();
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    rst_cfg('{MODE_XTAL_HIGH, 1'b1, 1'b0, 1'b0});
    rd(ADDR_OSC_CTRL, d, r);
    chk("two_speed", d[3], 0);
    rst_cfg('{MODE_EXT_CLK, 1'b0, 1'b1, 1'b0});
    for (n = 0; n < 30 && stall === 1'b1; n++) @(posedge clk);
    chk("ext_nocount", n, 2);
    slp <= 1'b1;
    repeat (5) @(posedge clk);
    slp <= 1'b0;
    for (n = 0; n < 30 && stall === 1'b1; n++) @(posedge clk);
    chk("wake_nocount", n, 2);
    run <= 1'b0;
    for (n = 0; n < 600 && fsafe !== 1'b1; n++) @(posedge clk);
    chk("fail_time", n >= 390 && n <= 415, 1);
    rd(ADDR_CLK_STAT, d, r);
    chk("fallback", d[0], 1);
    run <= 1'b1;
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    req = '0;
    req.bready = 1'b1;
    req.rready = 1'b1;
    @(posedge clk);
    t_xtal();
    t_regs();
    t_modes();
    t_fail();
    final_report();
  end
endmodule
`default_nettype wire
